//--- core/conv_regs_pkg.sv
// constants for the conversion control/status register bank
// assumes a 32-bit classic wishbone slave port and one 200 MHz clock
package conv_regs_pkg;
  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STAT_OFS        = 8'h04;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // ==========================================================
  // control fields
  localparam int C_ENABLE   = 0;
  localparam int C_CLKGATE  = 1;
  localparam int C_PCM_IE   = 2;
  localparam int C_WARN_IE  = 3;
  localparam int C_ERR_IE   = 4;
  localparam int C_OUT_DMA  = 5;
  localparam int C_IN_DMA   = 6;
  localparam int C_PCMO_DMA = 7;
  localparam int C_PCMI_DMA = 8;
  localparam int C_DELTA    = 9;
  localparam int C_LAW_LO   = 10;
  localparam int C_ATT_LO   = 12;
  localparam logic [15:0] CTRL_MASK = 16'h3FFF;
  // ==========================================================
  // status fields
  localparam int S_NEMPTY   = 0;
  localparam int S_NFULL    = 1;
  localparam int S_PCM      = 2;
  localparam int S_UNDER    = 3;
  localparam int S_OVER     = 4;
  localparam int S_INFREE   = 5;
  localparam int S_OUTVALID = 8;
  // ==========================================================
  // companding select codes
  localparam logic [1:0] LAW_LINEAR = 2'h0;
  localparam logic [1:0] LAW_ALAW   = 2'h1;
  localparam logic [1:0] LAW_ULAW   = 2'h2;
  localparam logic [15:0] ALAW_KEEP = 16'hFFF8;
  localparam logic [15:0] ULAW_KEEP = 16'hFFFC;
  // ==========================================================
  // fifo and timing
  localparam int FIFO_DEPTH     = 8;
  localparam int WARN_WORDS     = 3;
  localparam int CLK_HZ         = 200000000;
  localparam int CONV_CLK_HZ    = 2000000;
  localparam int CONV_DIV       = CLK_HZ / CONV_CLK_HZ;
endpackage

//--- core/conv_ctrl_stat.sv
// conversion control/status register bank with fifo fill tracking
// assumes converter and dma events are one-cycle pulses on clk_i
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_stat
  import conv_regs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // converter core events
  input  wire logic        freeze_i,
  input  wire logic        conv_in_pop_i,
  input  wire logic        conv_out_push_i,
  input  wire logic        conv_pcm_loaded_i,
  input  wire logic        conv_pcm_taken_i,
  // bus or dma side data accesses
  input  wire logic        in_fifo_write_i,
  input  wire logic        out_fifo_read_i,
  input  wire logic        pcm_out_read_i,
  input  wire logic        pcm_in_write_i,
  // pcm sample path
  input  wire logic [15:0] pcm_sample_i,
  output logic      [15:0] pcm_scaled_o,
  // converter controls
  output logic             iface_enable_o,
  output logic             conv_tick_o,
  output logic             in_pop_grant_o,
  output logic             out_push_grant_o,
  output logic             delta_conversion_select_o,
  output logic      [1:0]  companding_select_o,
  // interrupts and dma requests
  output logic             pcm_irq_o,
  output logic             warn_irq_o,
  output logic             err_irq_o,
  output logic             out_fifo_dma_req_o,
  output logic             in_fifo_dma_req_o,
  output logic             pcm_out_dma_req_o,
  output logic             pcm_in_dma_req_o
);

  // ==========================================================
  // free slot and valid word helpers
  function automatic logic [2:0] in_free(input logic [3:0] cnt);
    if (cnt >= 4'h7) begin
      in_free = 3'h0;
    end else if (cnt == 4'h0) begin
      in_free = 3'h7;
    end else begin
      in_free = 3'(4'h8 - cnt);
    end
  endfunction
  function automatic logic [2:0] out_valid(input logic [3:0] cnt);
    out_valid = (cnt >= 4'h7) ? 3'h7 : cnt[2:0];
  endfunction

  logic [15:0] conversion_control;
  logic [15:0] conversion_status;
  logic [3:0]  in_cnt;
  logic [3:0]  out_cnt;
  logic        in_fifo_nearly_empty;
  logic        out_fifo_nearly_full;
  logic        pcm_service_flag;
  logic        in_fifo_underrun;
  logic        out_fifo_overflow;
  logic        pcm_out_full;
  logic        pcm_in_empty;
  logic [6:0]  div_cnt;

  localparam logic [3:0] DEPTH_C = 4'(DEPTH);
  localparam logic [3:0] NE_LVL  = 4'(WARN_WORDS);
  localparam logic [3:0] NF_LVL  = 4'(DEPTH - WARN_WORDS);
  localparam logic [6:0] DIV_TOP = 7'(CONV_DIV - 1);

  wire logic enabled   = conversion_control[C_ENABLE];
  wire logic bus_req   = cyc_i && stb_i && !ack_o;
  wire logic ctrl_wr   = bus_req && we_i && adr_i == CTRL_OFS;
  wire logic stat_rd   = bus_req && !we_i && adr_i == STAT_OFS;
  wire logic pop_ev    = enabled && conv_in_pop_i && !freeze_i;
  wire logic push_ev   = enabled && conv_out_push_i && !freeze_i;
  wire logic loaded_ev = enabled && conv_pcm_loaded_i && !freeze_i;
  wire logic taken_ev  = enabled && conv_pcm_taken_i;
  wire logic wr_in_ev  = enabled && in_fifo_write_i && in_cnt != DEPTH_C;
  wire logic rd_out_ev = enabled && out_fifo_read_i && out_cnt != 4'h0;
  wire logic do_pop    = pop_ev && in_cnt != 4'h0;
  wire logic do_push   = push_ev && out_cnt != DEPTH_C;
  // sticky clear-on-read; freeze protects three of them
  wire logic rd_clr    = stat_rd;
  wire logic rd_clr_fz = stat_rd && !freeze_i;

  assign conversion_status = !enabled ? 16'h0000 : {5'h00, out_valid(out_cnt), in_free(in_cnt),
                              out_fifo_overflow, in_fifo_underrun, pcm_service_flag,
                              out_fifo_nearly_full, in_fifo_nearly_empty};

  // ==========================================================
  // control register
  // control write and reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_control <= CTRL_RESET;
    end else if (ce_i && ctrl_wr) begin
      if (sel_i[0]) begin
        conversion_control[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        conversion_control[15:8] <= dat_i[15:8] & CTRL_MASK[15:8];
      end
    end
  end

  // ==========================================================
  // wishbone answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          CTRL_OFS: dat_o <= {16'h0000, conversion_control};
          STAT_OFS: dat_o <= {16'h0000, conversion_status};
          default:  dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // fifo fill tracking
  // eight-word bounds
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !enabled)) begin
      in_cnt  <= 4'h0;
      out_cnt <= 4'h0;
    end else if (ce_i) begin
      in_cnt  <= 4'(in_cnt + {3'h0, wr_in_ev} - {3'h0, do_pop});
      out_cnt <= 4'(out_cnt + {3'h0, do_push} - {3'h0, rd_out_ev});
    end
  end

  // ==========================================================
  // pcm buffer state
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !enabled)) begin
      pcm_out_full <= 1'b0;
      pcm_in_empty <= 1'b0;
    end else if (ce_i) begin
      if (loaded_ev) begin
        pcm_out_full <= 1'b1;
      end else if (pcm_out_read_i) begin
        pcm_out_full <= 1'b0;
      end
      if (taken_ev) begin
        pcm_in_empty <= 1'b1;
      end else if (pcm_in_write_i) begin
        pcm_in_empty <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sticky status flags, set beats clear
  // disable forces status reset
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !enabled)) begin
      in_fifo_nearly_empty <= 1'b0;
      out_fifo_nearly_full <= 1'b0;
      pcm_service_flag     <= 1'b0;
      in_fifo_underrun     <= 1'b0;
      out_fifo_overflow    <= 1'b0;
    end else if (ce_i) begin
      if (do_pop && !wr_in_ev && in_cnt == NE_LVL + 4'h1) begin
        in_fifo_nearly_empty <= 1'b1;
      end else if (rd_clr) begin
        in_fifo_nearly_empty <= 1'b0;
      end
      if (do_push && !rd_out_ev && out_cnt == NF_LVL - 4'h1) begin
        out_fifo_nearly_full <= 1'b1;
      end else if (rd_clr) begin
        out_fifo_nearly_full <= 1'b0;
      end
      if (loaded_ev || taken_ev) begin
        pcm_service_flag <= 1'b1;
      end else if (rd_clr_fz) begin
        pcm_service_flag <= 1'b0;
      end
      if (pop_ev && in_cnt == 4'h0) begin
        in_fifo_underrun <= 1'b1;
      end else if (rd_clr_fz) begin
        in_fifo_underrun <= 1'b0;
      end
      if (push_ev && out_cnt == DEPTH_C) begin
        out_fifo_overflow <= 1'b1;
      end else if (rd_clr_fz) begin
        out_fifo_overflow <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt and dma requests, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcm_irq_o          <= 1'b0;
      warn_irq_o         <= 1'b0;
      err_irq_o          <= 1'b0;
      out_fifo_dma_req_o <= 1'b0;
      in_fifo_dma_req_o  <= 1'b0;
      pcm_out_dma_req_o  <= 1'b0;
      pcm_in_dma_req_o   <= 1'b0;
    end else if (ce_i) begin
      pcm_irq_o <= pcm_service_flag && conversion_control[C_PCM_IE];
      warn_irq_o <= (in_fifo_nearly_empty || out_fifo_nearly_full)
                    && conversion_control[C_WARN_IE];
      err_irq_o <= (in_fifo_underrun || out_fifo_overflow)
                   && conversion_control[C_ERR_IE];
      out_fifo_dma_req_o <= out_fifo_nearly_full && conversion_control[C_OUT_DMA];
      in_fifo_dma_req_o <= in_fifo_nearly_empty && conversion_control[C_IN_DMA];
      pcm_out_dma_req_o <= pcm_out_full && conversion_control[C_PCMO_DMA];
      pcm_in_dma_req_o <= pcm_in_empty && conversion_control[C_PCMI_DMA];
    end
  end

  // ==========================================================
  // converter controls and 2 MHz tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt     <= 7'h00;
      conv_tick_o <= 1'b0;
    end else if (ce_i) begin
      if (conversion_control[C_CLKGATE]) begin
        div_cnt     <= (div_cnt == DIV_TOP) ? 7'h00 : 7'(div_cnt + 7'h01);
        conv_tick_o <= div_cnt == DIV_TOP;
      end else begin
        div_cnt     <= 7'h00;
        conv_tick_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iface_enable_o            <= 1'b0;
      in_pop_grant_o            <= 1'b0;
      out_push_grant_o          <= 1'b0;
      delta_conversion_select_o <= 1'b0;
      companding_select_o       <= LAW_LINEAR;
    end else if (ce_i) begin
      iface_enable_o            <= enabled;
      in_pop_grant_o            <= do_pop;
      out_push_grant_o          <= do_push;
      delta_conversion_select_o <= conversion_control[C_DELTA];
      companding_select_o       <= conversion_control[C_LAW_LO +: 2];
    end
  end

  // ==========================================================
  // pcm attenuation path
  logic [15:0] stuffed;
  always_comb begin
    case (conversion_control[C_LAW_LO +: 2])
      LAW_ALAW: stuffed = pcm_sample_i & ALAW_KEEP;
      LAW_ULAW: stuffed = pcm_sample_i & ULAW_KEEP;
      default:  stuffed = pcm_sample_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcm_scaled_o <= 16'h0000;
    end else if (ce_i) begin
      pcm_scaled_o <= 16'($signed(stuffed) >>> conversion_control[C_ATT_LO +: 2]);
    end
  end

  // ==========================================================
  // checks
  sequence s_stat_read;
    stat_rd && ce_i;
  endsequence

  a_disable_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !enabled |=> conversion_status[4:0] == 5'h00)
    else $error("status not cleared while disabled");
  a_pcm_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> pcm_irq_o == ($past(pcm_service_flag) && $past(conversion_control[C_PCM_IE])))
    else $error("pcm interrupt gate wrong");
  a_err_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !conversion_control[C_ERR_IE] |=> !err_irq_o)
    else $error("error interrupt not suppressed");
  a_ne_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && do_pop && !wr_in_ev && in_cnt == 4'h4 |=> in_fifo_nearly_empty && in_cnt == 4'h3)
    else $error("nearly empty not set at three");
  a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_read ##0 (!freeze_i && !loaded_ev && !taken_ev) |=> !pcm_service_flag)
    else $error("pcm flag survived read");
  a_freeze_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_read ##0 (freeze_i && enabled && in_fifo_underrun) |=> in_fifo_underrun)
    else $error("underrun cleared during freeze");
  a_overflow_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && push_ev && out_cnt == 4'h8 |=> out_fifo_overflow && !out_push_grant_o)
    else $error("overflow not flagged");
  a_freeze_no_pop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && freeze_i && !in_fifo_write_i |=> $stable(in_cnt))
    else $error("fifo popped during freeze");
  a_in_fill_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    enabled && in_cnt == 4'h0 |-> conversion_status[7:5] == 3'h7)
    else $error("input fill field wrong when empty");
  a_tick_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !conversion_control[C_CLKGATE] |=> !conv_tick_o)
    else $error("tick while clock gated");
endmodule
`default_nettype wire

//--- tb/dma_model.sv
// dma channel stand-in: one transfer pulse for each new request that rises while no transfer is pending
// assumes registered request levels on the bench clock
`timescale 1ns/1ps
`default_nettype none
module dma_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // answer delay in cycles
  input  wire logic [3:0] wait_i,
  // requests in, transfers out
  input  wire logic       in_req_i,
  input  wire logic       out_req_i,
  output logic            in_write_o,
  output logic            out_read_o
);
  logic       in_q, out_q, in_p, out_p;
  logic [3:0] cnt;
  always_ff @(posedge clk_i) begin
    in_q       <= in_req_i;
    out_q      <= out_req_i;
    in_write_o <= 1'b0;
    out_read_o <= 1'b0;
    if (rst_i) begin
      in_p  <= 1'b0;
      out_p <= 1'b0;
    end else if ((in_p || out_p) && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (in_p || out_p) begin
      in_write_o <= in_p;
      out_read_o <= out_p;
      in_p       <= 1'b0;
      out_p      <= 1'b0;
    end else begin
      in_p  <= in_req_i && !in_q;
      out_p <= out_req_i && !out_q;
      cnt   <= wait_i;
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for conv_ctrl_stat with a dma stand-in
// assumes conv_regs_pkg, conv_ctrl_stat and dma_model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
  import conv_regs_pkg::*;
;
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, freeze_i, tb_wr, dma_wr;
  logic        conv_in_pop_i, conv_out_push_i, conv_pcm_loaded_i, conv_pcm_taken_i;
  logic        in_fifo_write_i, out_fifo_read_i, pcm_out_read_i, pcm_in_write_i;
  logic        iface_enable_o, conv_tick_o, in_pop_grant_o, out_push_grant_o;
  logic        delta_conversion_select_o, pcm_irq_o, warn_irq_o, err_irq_o;
  logic        out_fifo_dma_req_o, in_fifo_dma_req_o, pcm_out_dma_req_o, pcm_in_dma_req_o;
  logic [1:0]  companding_select_o;
  logic [3:0]  sel_i, dma_wait;
  logic [7:0]  adr_i;
  logic [15:0] pcm_sample_i, pcm_scaled_o;
  logic [31:0] dat_i, dat_o, rd, v;
  int          error_cnt, num_checks, cyc_cnt, n, pop_cnt, push_cnt;

  // bench and dma stand-in share the input fifo write strobe
  assign in_fifo_write_i = tb_wr | dma_wr;

  conv_ctrl_stat DUT (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .freeze_i, .conv_in_pop_i, .conv_out_push_i, .conv_pcm_loaded_i, .conv_pcm_taken_i,
    .in_fifo_write_i, .out_fifo_read_i, .pcm_out_read_i, .pcm_in_write_i, .pcm_sample_i,
    .pcm_scaled_o, .iface_enable_o, .conv_tick_o, .in_pop_grant_o, .out_push_grant_o,
    .delta_conversion_select_o, .companding_select_o, .pcm_irq_o, .warn_irq_o, .err_irq_o,
    .out_fifo_dma_req_o, .in_fifo_dma_req_o, .pcm_out_dma_req_o, .pcm_in_dma_req_o
  );
  dma_model partner (
    .clk_i, .rst_i, .wait_i(dma_wait), .in_req_i(in_fifo_dma_req_o),
    .out_req_i(out_fifo_dma_req_o), .in_write_o(dma_wr), .out_read_o(out_fifo_read_i)
  );

  // ==========================================
  // helpers
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack, bounded only by the timeout
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic ctl(input logic [31:0] d);
    wb(1'b1, CTRL_OFS, d);
  endtask

  // k: 0 pop, 1 push, 2 pcm loaded, 3 pcm taken, 4 input fifo write
  task automatic ev(input int k, input int times);
    repeat (times) begin
      @(posedge clk_i);
      {conv_in_pop_i, conv_out_push_i, conv_pcm_loaded_i, conv_pcm_taken_i, tb_wr} <= 5'h10 >> k;
      @(posedge clk_i);
      {conv_in_pop_i, conv_out_push_i, conv_pcm_loaded_i, conv_pcm_taken_i, tb_wr} <= 5'h00;
    end
  endtask

  task automatic ticks(output int t);
    t = 0;
    repeat (303) begin
      @(posedge clk_i);
      t += (conv_tick_o === 1'b1);
    end
  endtask

  function automatic logic [31:0] sx(input int iw, input int ow, input logic [4:0] f);
    int fr;
    fr = (iw <= 1) ? 7 : (iw >= 7) ? 0 : 8 - iw;
    return {21'h0, 3'(ow >= 7 ? 7 : ow), 3'(fr), f};
  endfunction

  function automatic logic [15:0] scale(input logic [15:0] s, input int law, input int at);
    logic [15:0] m;
    m = (law == 1) ? (s & ALAW_KEEP) : (law == 2) ? (s & ULAW_KEEP) : s;
    return 16'($signed(m) >>> at);
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // hang guard, far above the roughly one thousand cycles needed
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    pop_cnt  <= pop_cnt + int'(in_pop_grant_o === 1'b1);
    push_cnt <= push_cnt + int'(out_push_grant_o === 1'b1);
    if (cyc_cnt == 10000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    {ce_i, sel_i, rst_i, cyc_i, stb_i, we_i, freeze_i, tb_wr} = 11'h7E0;
    {conv_in_pop_i, conv_out_push_i, conv_pcm_loaded_i, conv_pcm_taken_i} = 4'h0;
    {pcm_out_read_i, pcm_in_write_i, adr_i, dat_i, pcm_sample_i, dma_wait} = '0;
    n = $urandom(97159);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 0);
    chk("ctrl reset", rd, 0);
    wb(1'b0, STAT_OFS, 0);
    chk("stat reset", rd, 0);
    repeat (4) begin
      v = $urandom();
      ctl(v);
      wb(1'b0, CTRL_OFS, 0);
      chk("ctrl rw", rd, v & {16'h0, CTRL_MASK});
      chk("delta", delta_conversion_select_o, v[C_DELTA]);
    end
    wb(1'b1, 8'h0C, $urandom());
    wb(1'b0, 8'h0C, 0);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 12; i++) begin
      ctl(1 | (i / 4) << C_LAW_LO | (i % 4) << C_ATT_LO);
      @(posedge clk_i);
      pcm_sample_i <= 16'($urandom());
      repeat (2) @(posedge clk_i);
      chk("scaled", 32'(pcm_scaled_o), 32'(scale(pcm_sample_i, i / 4, i % 4)));
      chk("law", 32'(companding_select_o), i / 4);
    end
    ctl(32'h3);
    for (n = 0; n < 200 && conv_tick_o !== 1'b1; n++) @(posedge clk_i);
    ticks(n);
    chk("ticks on", n, 3);
    ctl(32'h1);
    ticks(n);
    chk("ticks off", n, 0);
    ctl(1 | 1 << C_WARN_IE | 1 << C_ERR_IE | 1 << C_IN_DMA);
    ev(4, 9);
    wb(1'b0, STAT_OFS, 0);
    chk("in full", rd, sx(8, 0, 0));
    ev(0, 5);
    repeat (2) @(posedge clk_i);
    chk("warn irq", warn_irq_o, 1);
    chk("in dma", in_fifo_dma_req_o, 1);
    repeat (10) @(posedge clk_i);
    wb(1'b0, STAT_OFS, 0);
    chk("near empty", rd, sx(4, 0, 5'h01));
    freeze_i <= 1'b1;
    ev(0, 4);
    wb(1'b0, STAT_OFS, 0);
    chk("frozen pops", rd, sx(4, 0, 0));
    freeze_i <= 1'b0;
    ctl(1 | 1 << C_WARN_IE | 1 << C_ERR_IE);
    ev(0, 5);
    repeat (2) @(posedge clk_i);
    chk("err irq in", err_irq_o, 1);
    freeze_i <= 1'b1;
    wb(1'b0, STAT_OFS, 0);
    chk("underrun", rd, sx(0, 0, 5'h09));
    freeze_i <= 1'b0;
    wb(1'b0, STAT_OFS, 0);
    chk("frozen kept", rd, sx(0, 0, 5'h08));
    wb(1'b0, STAT_OFS, 0);
    chk("read clear", rd, sx(0, 0, 0));
    dma_wait <= 4'h7;
    ctl(1 | 1 << C_WARN_IE | 1 << C_ERR_IE | 1 << C_OUT_DMA);
    ev(1, 5);
    repeat (16) @(posedge clk_i);
    wb(1'b0, STAT_OFS, 0);
    chk("near full", rd, sx(0, 4, 5'h02));
    ctl(1 | 1 << C_ERR_IE);
    ev(1, 5);
    repeat (2) @(posedge clk_i);
    chk("err irq out", err_irq_o, 1);
    wb(1'b0, STAT_OFS, 0);
    chk("overflow", rd, sx(0, 8, 5'h12));
    ctl(1 | 1 << C_PCM_IE | 1 << C_PCMO_DMA);
    ev(2, 1);
    repeat (2) @(posedge clk_i);
    chk("pcm irq", pcm_irq_o, 1);
    chk("pcm out dma", pcm_out_dma_req_o, 1);
    pcm_out_read_i <= 1'b1;
    @(posedge clk_i);
    pcm_out_read_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pcm out served", pcm_out_dma_req_o, 0);
    ctl(1 | 1 << C_PCMI_DMA);
    wb(1'b0, STAT_OFS, 0);
    chk("pcm flag", rd, sx(0, 8, 5'h04));
    ev(3, 1);
    repeat (2) @(posedge clk_i);
    chk("pcm in dma", pcm_in_dma_req_o, 1);
    chk("pcm irq off", pcm_irq_o, 0);
    pcm_in_write_i <= 1'b1;
    @(posedge clk_i);
    pcm_in_write_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pcm in served", pcm_in_dma_req_o, 0);
    ctl(32'h0);
    repeat (2) @(posedge clk_i);
    chk("iface off", iface_enable_o, 0);
    wb(1'b0, STAT_OFS, 0);
    chk("disabled", rd, 0);
    ctl(32'h1);
    repeat (2) @(posedge clk_i);
    chk("iface on", iface_enable_o, 1);
    chk("pop grants", pop_cnt, 9);
    chk("push grants", push_cnt, 9);
    close_out();
  end
endmodule
`default_nettype wire
